/* logic/dcc_pkg.sv */
// Overview of operation
// - Word-size bit set moves 16-bit words, clear moves single bytes.
// - An indexed pointer steps by two for words and one for bytes.
// - Destination space bit set selects memory, clear selects I/O space.
// - Source space bit set selects memory, clear selects I/O space.
// - Pointer goes up or down per its own bit; equal bits keep it.
// - Halt-at-zero stops transfers at terminal count; unsynchronized mode always halts.
// - Terminal-count interrupt only with interrupt-enable and halt-at-zero both set.
// - Sync field: 00 none, 01 source, 10 destination, 11 reserved.
// - Priority bit set means high relative priority, clear means low.
// - Internal select takes only timer requests; clear takes only the pin.
// - No requests are recognized unless armed; the armed bit resets to zero.
// - A control write changes the armed bit only with arm-change-enable set.
// - Disarm by software write or automatically at terminal count with halting.
// - Unsynchronized mode starts transferring as soon as the channel is armed.
// - The 16-bit counter drops by exactly one after every transfer.
// - Synchronized with halt-at-zero clear keeps transferring whatever the count.
// - The 8-bit bus variant ignores word size and always moves bytes.
// - Each transfer fetches via the source pointer then deposits via destination.
// - Destination-synchronized mode inserts two idle states after each deposit.
package dcc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned DCC_ADDR_W = 3;
    localparam logic [2:0] DCC_OFF_SRC_LOW = 3'h0;
    localparam logic [2:0] DCC_OFF_SRC_HIGH = 3'h1;
    localparam logic [2:0] DCC_OFF_DST_LOW = 3'h2;
    localparam logic [2:0] DCC_OFF_DST_HIGH = 3'h3;
    localparam logic [2:0] DCC_OFF_COUNT = 3'h4;
    localparam logic [2:0] DCC_OFF_CONTROL = 3'h5;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int unsigned DCC_B_DST_MEM = 15;
    localparam int unsigned DCC_B_DST_DOWN = 14;
    localparam int unsigned DCC_B_DST_UP = 13;
    localparam int unsigned DCC_B_SRC_MEM = 12;
    localparam int unsigned DCC_B_SRC_DOWN = 11;
    localparam int unsigned DCC_B_SRC_UP = 10;
    localparam int unsigned DCC_B_HALT = 9;
    localparam int unsigned DCC_B_INT_EN = 8;
    localparam int unsigned DCC_B_SYNC_HI = 7;
    localparam int unsigned DCC_B_SYNC_LO = 6;
    localparam int unsigned DCC_B_PRIO = 5;
    localparam int unsigned DCC_B_INT_REQ = 4;
    localparam int unsigned DCC_B_CHG = 2;
    localparam int unsigned DCC_B_ARMED = 1;
    localparam int unsigned DCC_B_WORD = 0;
    // Bits software stores directly; the armed bit and the change enable are handled apart.
    localparam logic [15:0] DCC_CTL_WR_MASK = 16'hfff1;

    // ----------------------------------------------------------------
    // Reset values and steps
    // ----------------------------------------------------------------
    localparam logic [15:0] DCC_CTL_RESET = 16'h0000;
    localparam logic [15:0] DCC_CNT_RESET = 16'h0000;
    localparam logic [19:0] DCC_PTR_RESET = 20'h00000;
    localparam logic [15:0] DCC_DATA_RESET = 16'h0000;
    localparam logic [19:0] DCC_STEP_BYTE = 20'h00001;
    localparam logic [19:0] DCC_STEP_WORD = 20'h00002;
    localparam logic [15:0] DCC_CNT_ONE = 16'h0001;

    // ----------------------------------------------------------------
    // Modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DCC_SYNC_NONE = 2'h0,
        DCC_SYNC_SRC = 2'h1,
        DCC_SYNC_DST = 2'h2,
        DCC_SYNC_RSVD = 2'h3
    } dcc_sync_t;

    typedef enum logic [2:0] {
        DCC_PH_IDLE = 3'h0,
        DCC_PH_FETCH = 3'h1,
        DCC_PH_DEPOSIT = 3'h3,
        DCC_PH_GAP1 = 3'h2,
        DCC_PH_GAP2 = 3'h6
    } dcc_phase_t;

    typedef struct packed {
        dcc_phase_t phase;
        logic [15:0] ctl;
        logic [15:0] cnt;
        logic [19:0] src;
        logic [19:0] dst;
        logic [15:0] data;
        logic req_meta;
        logic req_sync;
        logic [15:0] rd_data;
        logic irq;
    } dcc_regs_t;

endpackage

/* logic/dcc_channel_control.sv */
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dcc_channel_control #(
    parameter bit BUS8_VARIANT = 1'b0
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [dcc_pkg::DCC_ADDR_W-1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    input wire logic i_external_request_pin,
    input wire logic i_timer_req,
    output logic o_bus_req,
    output logic o_bus_fetch,
    output logic o_bus_word,
    output logic o_bus_is_mem,
    output logic [19:0] o_bus_addr,
    output logic [15:0] o_bus_wdata,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_rdata,
    output logic o_high_priority,
    output logic o_tc_irq,
    output logic o_armed
);
    import dcc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dcc_regs_t q;
    dcc_regs_t d;
    dcc_regs_t reset_state;

    logic armed;
    logic word_eff;
    logic halt_eff;
    logic req_sel;
    logic start_ok;
    logic deposit_done;
    logic fetch_done;
    logic [19:0] step;
    logic [15:0] cnt_next;
    dcc_sync_t sync_mode;

    assign reset_state = '{phase: DCC_PH_IDLE, ctl: DCC_CTL_RESET, cnt: DCC_CNT_RESET,
                           src: DCC_PTR_RESET, dst: DCC_PTR_RESET, data: DCC_DATA_RESET,
                           req_meta: 1'b0, req_sync: 1'b0, rd_data: DCC_DATA_RESET, irq: 1'b0};

    function automatic logic [19:0] next_ptr(input logic [19:0] p, input logic up, input logic down,
                                             input logic [19:0] inc);
        logic [19:0] r;
        r = p;
        if (up && !down)
        begin
            r = p + inc;
        end
        else if (down && !up)
        begin
            r = p - inc;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Decoded control
    // ----------------------------------------------------------------
    assign armed = q.ctl[DCC_B_ARMED];
    assign sync_mode = dcc_sync_t'(q.ctl[DCC_B_SYNC_HI:DCC_B_SYNC_LO]);
    // The narrow-bus variant cannot carry a word, so the size bit is dropped here once.
    assign word_eff = q.ctl[DCC_B_WORD] && !BUS8_VARIANT;
    assign step = word_eff ? DCC_STEP_WORD : DCC_STEP_BYTE;
    assign halt_eff = q.ctl[DCC_B_HALT] || (sync_mode == DCC_SYNC_NONE);
    assign req_sel = q.ctl[DCC_B_INT_REQ] ? i_timer_req : q.req_sync;
    // The reserved sync encoding never starts a transfer, which keeps it harmless.
    assign start_ok = armed && ((sync_mode == DCC_SYNC_NONE) ||
                      (((sync_mode == DCC_SYNC_SRC) || (sync_mode == DCC_SYNC_DST)) && req_sel));
    assign fetch_done = (q.phase == DCC_PH_FETCH) && i_bus_ack;
    assign deposit_done = (q.phase == DCC_PH_DEPOSIT) && i_bus_ack;
    assign cnt_next = q.cnt - DCC_CNT_ONE;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.irq = 1'b0;
        d.rd_data = 16'h0000;
        d.req_meta = i_external_request_pin;
        d.req_sync = q.req_meta;
        case (q.phase)
            DCC_PH_IDLE:
            begin
                if (start_ok)
                begin
                    d.phase = DCC_PH_FETCH;
                end
            end
            DCC_PH_FETCH:
            begin
                if (i_bus_ack)
                begin
                    d.data = i_bus_rdata;
                    d.phase = DCC_PH_DEPOSIT;
                end
            end
            DCC_PH_DEPOSIT:
            begin
                if (i_bus_ack)
                begin
                    d.src = next_ptr(q.src, q.ctl[DCC_B_SRC_UP], q.ctl[DCC_B_SRC_DOWN], step);
                    d.dst = next_ptr(q.dst, q.ctl[DCC_B_DST_UP], q.ctl[DCC_B_DST_DOWN], step);
                    d.cnt = cnt_next;
                    if (halt_eff && (cnt_next == 16'h0000))
                    begin
                        d.ctl[DCC_B_ARMED] = 1'b0;
                        d.irq = q.ctl[DCC_B_INT_EN] && q.ctl[DCC_B_HALT];
                    end
                    d.phase = (sync_mode == DCC_SYNC_DST) ? DCC_PH_GAP1 : DCC_PH_IDLE;
                end
            end
            DCC_PH_GAP1:
            begin
                d.phase = DCC_PH_GAP2;
            end
            DCC_PH_GAP2:
            begin
                d.phase = DCC_PH_IDLE;
            end
            default:
            begin
                d.phase = DCC_PH_IDLE;
            end
        endcase

        // Software writes come last so a write in the same cycle as a hardware update wins.
        if (i_reg_wr)
        begin
            if (i_reg_addr == DCC_OFF_SRC_LOW)
            begin
                d.src[15:0] = i_reg_wdata;
            end
            else if (i_reg_addr == DCC_OFF_SRC_HIGH)
            begin
                d.src[19:16] = i_reg_wdata[3:0];
            end
            else if (i_reg_addr == DCC_OFF_DST_LOW)
            begin
                d.dst[15:0] = i_reg_wdata;
            end
            else if (i_reg_addr == DCC_OFF_DST_HIGH)
            begin
                d.dst[19:16] = i_reg_wdata[3:0];
            end
            else if (i_reg_addr == DCC_OFF_COUNT)
            begin
                d.cnt = i_reg_wdata;
            end
            else if (i_reg_addr == DCC_OFF_CONTROL)
            begin
                d.ctl = (i_reg_wdata & DCC_CTL_WR_MASK) | {14'h0000, d.ctl[DCC_B_ARMED], 1'b0};
                if (i_reg_wdata[DCC_B_CHG])
                begin
                    d.ctl[DCC_B_ARMED] = i_reg_wdata[DCC_B_ARMED];
                end
            end
        end

        if (i_reg_rd)
        begin
            if (i_reg_addr == DCC_OFF_SRC_LOW)
            begin
                d.rd_data = q.src[15:0];
            end
            else if (i_reg_addr == DCC_OFF_SRC_HIGH)
            begin
                d.rd_data = {12'h000, q.src[19:16]};
            end
            else if (i_reg_addr == DCC_OFF_DST_LOW)
            begin
                d.rd_data = q.dst[15:0];
            end
            else if (i_reg_addr == DCC_OFF_DST_HIGH)
            begin
                d.rd_data = {12'h000, q.dst[19:16]};
            end
            else if (i_reg_addr == DCC_OFF_COUNT)
            begin
                d.rd_data = q.cnt;
            end
            else if (i_reg_addr == DCC_OFF_CONTROL)
            begin
                d.rd_data = q.ctl;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            q <= reset_state;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_reg_rdata = q.rd_data;
    assign o_bus_req = (q.phase == DCC_PH_FETCH) || (q.phase == DCC_PH_DEPOSIT);
    assign o_bus_fetch = (q.phase == DCC_PH_FETCH);
    assign o_bus_word = word_eff;
    assign o_bus_is_mem = o_bus_fetch ? q.ctl[DCC_B_SRC_MEM] : q.ctl[DCC_B_DST_MEM];
    assign o_bus_addr = o_bus_fetch ? q.src : q.dst;
    assign o_bus_wdata = q.data;
    assign o_high_priority = q.ctl[DCC_B_PRIO];
    assign o_tc_irq = q.irq;
    assign o_armed = armed;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    logic ctl_wr;
    logic src_wr;
    logic cnt_wr;
    logic dst_wr;
    assign ctl_wr = i_reg_wr && (i_reg_addr == DCC_OFF_CONTROL);
    assign src_wr = i_reg_wr && ((i_reg_addr == DCC_OFF_SRC_LOW) || (i_reg_addr == DCC_OFF_SRC_HIGH));
    assign cnt_wr = i_reg_wr && (i_reg_addr == DCC_OFF_COUNT);
    assign dst_wr = i_reg_wr && ((i_reg_addr == DCC_OFF_DST_LOW) || (i_reg_addr == DCC_OFF_DST_HIGH));

    sequence s_deposit_dst;
        deposit_done && (sync_mode == DCC_SYNC_DST);
    endsequence

    sequence s_two_gaps;
        (q.phase == DCC_PH_GAP1) && !o_bus_req ##1 (q.phase == DCC_PH_GAP2) && !o_bus_req ##1 q.phase == DCC_PH_IDLE;
    endsequence

    sequence s_fetch_ack;
        fetch_done ##1 (o_bus_req && !o_bus_fetch);
    endsequence

    sequence s_fetch_begins;
        o_bus_req && o_bus_fetch && (o_bus_addr == q.src);
    endsequence

    a_unarmed_stays_idle: assert property ((q.phase == DCC_PH_IDLE) && !armed |=> q.phase == DCC_PH_IDLE)
        else $error("unarmed channel left idle");
    a_unsync_starts_now: assert property ((q.phase == DCC_PH_IDLE) && armed && (sync_mode == DCC_SYNC_NONE)
        |=> o_bus_req && o_bus_fetch)
        else $error("unsynchronized channel did not start");
    a_dest_gap_two: assert property (s_deposit_dst |=> s_two_gaps)
        else $error("destination-synchronized gap wrong");
    a_fetch_then_deposit: assert property (s_fetch_ack |-> o_bus_addr == q.dst && o_bus_wdata == $past(i_bus_rdata))
        else $error("deposit did not follow fetch");
    a_count_minus_one: assert property (deposit_done && !cnt_wr |=> q.cnt == $past(q.cnt) - DCC_CNT_ONE)
        else $error("counter not decremented by one");
    a_halt_disarms: assert property (deposit_done && halt_eff && (q.cnt == DCC_CNT_ONE) && !ctl_wr |=> !armed)
        else $error("channel not disarmed at terminal count");
    a_no_halt_keeps: assert property (deposit_done && !halt_eff && !ctl_wr |=> armed == $past(armed))
        else $error("synchronized channel without halting disarmed");
    a_irq_needs_both: assert property (o_tc_irq |-> q.ctl[DCC_B_INT_EN] && q.ctl[DCC_B_HALT] && !armed)
        else $error("interrupt raised without both enables");
    a_arm_guard: assert property (ctl_wr && !i_reg_wdata[DCC_B_CHG] && !deposit_done |=> armed == $past(armed))
        else $error("armed bit changed without change enable");
    a_src_step: assert property (deposit_done && !src_wr && q.ctl[DCC_B_SRC_UP] && !q.ctl[DCC_B_SRC_DOWN]
        |=> q.src == $past(q.src) + $past(step))
        else $error("source pointer step wrong");
    a_src_equal_hold: assert property (deposit_done && !src_wr && (q.ctl[DCC_B_SRC_UP] == q.ctl[DCC_B_SRC_DOWN])
        |=> q.src == $past(q.src))
        else $error("source pointer moved with equal bits");
    a_internal_ignores: assert property ((q.phase == DCC_PH_IDLE) && q.ctl[DCC_B_INT_REQ] && !i_timer_req
        && (sync_mode != DCC_SYNC_NONE) |=> q.phase == DCC_PH_IDLE)
        else $error("internal select took the pin");
    a_narrow_bytes: assert property (BUS8_VARIANT |-> !o_bus_word)
        else $error("narrow variant moved a word");

    // ----------------------------------------------------------------
    // Pointer, field and request checks
    // ----------------------------------------------------------------
    // A software write to a pointer in the deposit-ack cycle wins, so those cycles are left out.
    a_src_step_down: assert property (deposit_done && !src_wr && q.ctl[DCC_B_SRC_DOWN] && !q.ctl[DCC_B_SRC_UP]
        |=> q.src == $past(q.src) - $past(step))
        else $error("source pointer down step wrong");
    a_dst_step_down: assert property (deposit_done && !dst_wr && q.ctl[DCC_B_DST_DOWN] && !q.ctl[DCC_B_DST_UP]
        |=> q.dst == $past(q.dst) - $past(step))
        else $error("destination pointer step wrong");
    a_dst_equal_hold: assert property (deposit_done && !dst_wr
        && (q.ctl[DCC_B_DST_UP] == q.ctl[DCC_B_DST_DOWN]) |=> q.dst == $past(q.dst))
        else $error("destination pointer moved with equal bits");
    a_unsync_halts: assert property (deposit_done && (sync_mode == DCC_SYNC_NONE)
        && (q.cnt == DCC_CNT_ONE) && !ctl_wr |=> !armed)
        else $error("unsynchronized channel ran past terminal count");
    a_irq_one_pulse: assert property (o_tc_irq |=> !o_tc_irq)
        else $error("terminal count interrupt longer than one cycle");
    a_reserved_idle: assert property ((q.phase == DCC_PH_IDLE) && (sync_mode == DCC_SYNC_RSVD)
        |=> q.phase == DCC_PH_IDLE)
        else $error("reserved sync encoding started a transfer");
    a_prio_follows: assert property (ctl_wr |=> o_high_priority == $past(i_reg_wdata[DCC_B_PRIO]))
        else $error("priority bit not taken from write");
    a_timer_starts: assert property ((q.phase == DCC_PH_IDLE) && armed && q.ctl[DCC_B_INT_REQ] && i_timer_req
        && (sync_mode == DCC_SYNC_SRC) |=> s_fetch_begins)
        else $error("timer request did not start a transfer");
    a_pin_ignored: assert property ((q.phase == DCC_PH_IDLE) && !q.ctl[DCC_B_INT_REQ] && !q.req_sync
        && (sync_mode != DCC_SYNC_NONE) |=> q.phase == DCC_PH_IDLE)
        else $error("pin select started without a pin request");
    a_fields_follow: assert property (ctl_wr
        |=> (q.ctl & DCC_CTL_WR_MASK) == ($past(i_reg_wdata) & DCC_CTL_WR_MASK))
        else $error("control fields not taken from write");
    a_arm_by_write: assert property (ctl_wr && i_reg_wdata[DCC_B_CHG]
        |=> armed == $past(i_reg_wdata[DCC_B_ARMED]))
        else $error("armed bit not taken with change enable");
    a_read_idle_zero: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data shown without a read");

endmodule

/* verif/dcc_bus_peer.sv */
`timescale 1ns/1ns
module dcc_bus_peer (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_req_on,
    input wire logic [1:0] i_delay,
    input wire logic i_bus_req,
    input wire logic i_bus_fetch,
    input wire logic i_bus_word,
    input wire logic i_bus_is_mem,
    input wire logic [19:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    output logic o_request_pin,
    output logic o_bus_ack,
    output logic [15:0] o_bus_rdata
);
    logic [1:0] wait_q;
    logic [15:0] data_q;
    logic req_d;
    logic [3:0] gap_q;
    logic [3:0] last_gap;
    logic [15:0] dep_cnt;
    logic [19:0] fetch_addr;
    logic [19:0] dep_addr;
    logic [15:0] dep_data;
    logic fetch_mem;
    logic dep_mem;
    logic dep_word;
    // The peripheral holds its request level for as long as it has work.
    assign o_request_pin = i_req_on;
    // Outside the acknowledge cycle the data lines never show a stale copy.
    assign o_bus_rdata = o_bus_ack ? data_q : ~data_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            {wait_q, data_q, req_d, gap_q, last_gap, dep_cnt, o_bus_ack} <= '0;
            {fetch_addr, dep_addr, dep_data, fetch_mem, dep_mem, dep_word} <= '0;
        end
        else
        begin
            o_bus_ack <= 1'b0;
            req_d <= i_bus_req;
            if (i_bus_req && !o_bus_ack)
            begin
                if (wait_q == i_delay)
                begin
                    o_bus_ack <= 1'b1;
                    wait_q <= 2'h0;
                    data_q <= i_bus_addr[15:0] ^ 16'h5a3c;
                end
                else
                begin
                    wait_q <= wait_q + 2'h1;
                end
            end
            if (o_bus_ack && i_bus_fetch)
            begin
                fetch_addr <= i_bus_addr;
                fetch_mem <= i_bus_is_mem;
            end
            if (o_bus_ack && !i_bus_fetch)
            begin
                dep_cnt <= dep_cnt + 16'h0001;
                dep_addr <= i_bus_addr;
                dep_data <= i_bus_wdata;
                dep_mem <= i_bus_is_mem;
                dep_word <= i_bus_word;
                gap_q <= 4'h0;
            end
            else if (!i_bus_req)
            begin
                gap_q <= gap_q + 4'h1;
            end
            if (i_bus_req && !req_d)
            begin
                last_gap <= gap_q;
            end
        end
    end
endmodule

/* verif/dcc_channel_control_tb_top.sv */
`timescale 1ns/1ns
module dcc_channel_control_tb_top;
    import dcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic timer = 1'b0;
    logic req_on = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [15:0] rdata;
    logic pin, breq, bfetch, bword, bmem, back, hprio, irq, armed, bword8;
    logic [19:0] baddr;
    logic [15:0] bwdata, brdata, d0;
    int err_count = 0;
    int check_count = 0;
    int irq_cnt = 0;
    dcc_channel_control DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_external_request_pin(pin), .i_timer_req(timer),
        .o_bus_req(breq), .o_bus_fetch(bfetch), .o_bus_word(bword), .o_bus_is_mem(bmem), .o_bus_addr(baddr),
        .o_bus_wdata(bwdata), .i_bus_ack(back), .i_bus_rdata(brdata), .o_high_priority(hprio),
        .o_tc_irq(irq), .o_armed(armed));
    dcc_bus_peer peer (.i_clk_sys(clk), .i_reset_n(rst_n), .i_req_on(req_on), .i_delay(dly), .i_bus_req(breq),
        .i_bus_fetch(bfetch), .i_bus_word(bword), .i_bus_is_mem(bmem), .i_bus_addr(baddr),
        .i_bus_wdata(bwdata), .o_request_pin(pin), .o_bus_ack(back), .o_bus_rdata(brdata));
    // The narrow variant follows the same stimulus; only its size output is judged.
    dcc_channel_control #(.BUS8_VARIANT(1'b1)) DUT_NARROW (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(), .i_external_request_pin(pin),
        .i_timer_req(timer), .o_bus_req(), .o_bus_fetch(), .o_bus_word(bword8), .o_bus_is_mem(), .o_bus_addr(),
        .o_bus_wdata(), .i_bus_ack(back), .i_bus_rdata(brdata), .o_high_priority(), .o_tc_irq(), .o_armed());
    always #4 clk = ~clk;
    always @(negedge clk) if (irq === 1'b1) irq_cnt++;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check_val(20'(rdata), 20'(exp));
    endtask
    task automatic setup(input logic [19:0] s, input logic [19:0] d, input logic [15:0] n);
        reg_wr(3'h0, s[15:0]);
        reg_wr(3'h1, 16'(s[19:16]));
        reg_wr(3'h2, d[15:0]);
        reg_wr(3'h3, 16'(d[19:16]));
        reg_wr(3'h4, n);
        d0 = peer.dep_cnt;
    endtask
    task automatic wait_deps(input logic [15:0] n);
        for (int i = 0; i < 400 && peer.dep_cnt < n; i++) @(posedge clk);
        if (peer.dep_cnt < n) check_val(20'(peer.dep_cnt), 20'(n));
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 6; a++) rd_chk(3'(a), 16'h0000);
        check_val(20'(armed), 20'h0);
        reg_wr(3'h1, 16'h000a);
        rd_chk(3'h1, 16'h000a);
        reg_wr(3'h7, 16'hffff);
        rd_chk(3'h7, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_unsync_word();
        int i0 = irq_cnt;
        dly <= 2'h2;
        setup(20'h01000, 20'h20100, 16'h0002);
        reg_wr(3'h5, 16'h5707);
        check_val(20'(bword), 20'h1);
        check_val(20'(bword8), 20'h0);
        wait_deps(d0 + 16'h0002);
        repeat (4) @(posedge clk);
        check_val(20'(peer.dep_cnt - d0), 20'h2);
        check_val(20'(armed), 20'h0);
        check_val(20'(irq_cnt - i0), 20'h1);
        rd_chk(3'h4, 16'h0000);
        rd_chk(3'h0, 16'h1004);
        rd_chk(3'h2, 16'h00fc);
        rd_chk(3'h5, 16'h5701);
        check_val(peer.fetch_addr, 20'h01002);
        check_val(peer.dep_addr, 20'h200fe);
        check_val(20'(peer.dep_data), 20'(16'h1002 ^ 16'h5a3c));
        check_val(20'({peer.fetch_mem, peer.dep_mem, peer.dep_word}), 20'h5);
        $display("test unsync word done");
    endtask
    task automatic t_unsync_byte();
        int i0 = irq_cnt;
        dly <= 2'h0;
        setup(20'h00300, 20'h00400, 16'h0001);
        reg_wr(3'h5, 16'h0106);
        wait_deps(d0 + 16'h0001);
        repeat (6) @(posedge clk);
        check_val(20'(peer.dep_cnt - d0), 20'h1);
        check_val(20'(armed), 20'h0);
        check_val(20'(irq_cnt - i0), 20'h0);
        check_val(20'(peer.dep_word), 20'h0);
        rd_chk(3'h0, 16'h0300);
        check_val(peer.dep_addr, 20'h00400);
        $display("test unsync byte done");
    endtask
    task automatic t_arm_guard();
        setup(20'h0, 20'h0, 16'h0001);
        reg_wr(3'h5, 16'h0002);
        repeat (10) @(posedge clk);
        check_val(20'(armed), 20'h0);
        check_val(20'(peer.dep_cnt), 20'(d0));
        reg_wr(3'h5, 16'h0046);
        repeat (10) @(posedge clk);
        check_val(20'(armed), 20'h1);
        check_val(20'(peer.dep_cnt), 20'(d0));
        timer <= 1'b1;
        repeat (10) @(posedge clk);
        timer <= 1'b0;
        check_val(20'(peer.dep_cnt), 20'(d0));
        reg_wr(3'h5, 16'h0044);
        check_val(20'(armed), 20'h0);
        rd_chk(3'h5, 16'h0040);
        $display("test arm guard done");
    endtask
    task automatic t_pin_run();
        logic [15:0] n;
        dly <= 2'h1;
        setup(20'h00800, 20'h0, 16'h0001);
        reg_wr(3'h5, 16'h0846);
        req_on <= 1'b1;
        wait_deps(d0 + 16'h0003);
        req_on <= 1'b0;
        repeat (12) @(posedge clk);
        n = peer.dep_cnt - d0;
        check_val(20'(armed), 20'h1);
        rd_chk(3'h4, 16'h0001 - n);
        rd_chk(3'h0, 16'h0800 - n);
        check_val(20'(peer.last_gap), 20'h1);
        reg_wr(3'h5, 16'h0004);
        $display("test pin run done");
    endtask
    task automatic t_timer();
        int i0 = irq_cnt;
        dly <= 2'h0;
        setup(20'h0, 20'h0, 16'h0002);
        reg_wr(3'h5, 16'h0256);
        req_on <= 1'b1;
        repeat (10) @(posedge clk);
        req_on <= 1'b0;
        check_val(20'(peer.dep_cnt), 20'(d0));
        timer <= 1'b1;
        wait_deps(d0 + 16'h0002);
        timer <= 1'b0;
        repeat (6) @(posedge clk);
        check_val(20'(peer.dep_cnt - d0), 20'h2);
        check_val(20'(armed), 20'h0);
        check_val(20'(irq_cnt - i0), 20'h0);
        $display("test timer done");
    endtask
    task automatic t_dst_sync();
        setup(20'h0, 20'h0, 16'h0001);
        reg_wr(3'h5, 16'h00a6);
        check_val(20'(hprio), 20'h1);
        req_on <= 1'b1;
        wait_deps(d0 + 16'h0002);
        req_on <= 1'b0;
        repeat (12) @(posedge clk);
        check_val(20'(peer.last_gap), 20'h3);
        reg_wr(3'h5, 16'h0004);
        check_val(20'(hprio), 20'h0);
        setup(20'h0, 20'h0, 16'h0001);
        reg_wr(3'h5, 16'h0084);
        req_on <= 1'b1;
        repeat (12) @(posedge clk);
        req_on <= 1'b0;
        check_val(20'(peer.dep_cnt), 20'(d0));
        reg_wr(3'h5, 16'h0004);
        $display("test dest sync done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_unsync_word();
        t_unsync_byte();
        t_arm_guard();
        t_pin_run();
        t_timer();
        t_dst_sync();
        test_done();
    end
    // A hang in any wait still ends in the same verdict.
    initial
    begin
        #400000;
        err_count++;
        test_done();
    end
endmodule
